// *** dcm_clkdiv.v ***
// dot clock divider working on reference clock enable ticks
`timescale 1ns/1ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_clkdiv (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // control
  input  wire       ref_tick,
  input  wire [5:0] ratio_m,
  // dot clock
  output reg        dclk_r,
  output wire       dclk_rise,
  output wire       dclk_fall
);
  reg  [5:0] cnt_r;
  wire [6:0] ratio = {1'b0, ratio_m} + 7'h01;
  wire [5:0] half  = ratio[6:1];
  wire       wrap  = (cnt_r == ratio_m);
  wire       undiv = (ratio_m == `DCM_SC_ZERO);
  // undivided dot clock toggles on every tick, so it runs at half the tick rate
  assign dclk_rise = ref_tick & (undiv ? ~dclk_r : wrap);
  assign dclk_fall = ref_tick & (undiv ? dclk_r : (cnt_r == half - 6'h01) & ~wrap);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 6'h00;
      dclk_r <= 1'b0;
    end else if (ref_tick) begin
      cnt_r <= (wrap || cnt_r > ratio_m) ? 6'h00 : cnt_r + 6'h01;
      if (dclk_rise)
        dclk_r <= 1'b1;
      else if (dclk_fall)
        dclk_r <= 1'b0;
    end
  end
endmodule // dcm_clkdiv
`default_nettype wire

// *** dcm_consts.vh ***
// constants shared by the display control mode block
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH
// register byte offsets
`define DCM_OFS_PRIMARY   12'h000
`define DCM_OFS_ALTERNATE 12'h100
`define DCM_OFS_UPDATE    12'h104
`define DCM_OFS_DOTCLK    12'h108
// mode register field positions
`define DCM_SYNC_LO  0
`define DCM_SYNC_HI  1
`define DCM_ESY_BIT  2
`define DCM_SF_BIT   3
`define DCM_B5_BIT   5
`define DCM_ODE_BIT  6
`define DCM_EEQ_BIT  7
`define DCM_SC_LO    8
`define DCM_SC_HI    13
`define DCM_CKS_BIT  15
`define DCM_L0_BIT   16
`define DCM_L1_BIT   17
`define DCM_L2_BIT   18
`define DCM_L3_BIT   19
`define DCM_L4_BIT   20
`define DCM_L5_BIT   21
`define DCM_STOP_BIT 30
`define DCM_DEN_BIT  31
// writable bits of the mode register in alternate format
`define DCM_ALT_MASK    32'hC03FBFEF
// mode register reset value: scaling field 6'h1D
`define DCM_MODE_RESET  32'h00001D00
// update control fields
`define DCM_RUM_BIT  0
`define DCM_RUF_BIT  1
// dot clock control fields
`define DCM_DLY_LO   0
`define DCM_DLY_HI   5
`define DCM_INV_BIT  8
`define DCM_EDGE_BIT 9
`define DCM_POM_BIT  10
`define DCM_DOT_MASK 32'h0000073F
// scaling values treated specially
`define DCM_SC_ZERO     6'h00
`define DCM_SC_PLL_MAX  6'h04
// dot clock delay line depth in system clock periods
`define DCM_DLY_DEPTH 34
`endif

// *** dcm_dly.v ***
// dot clock delay line counted in system clock periods
`timescale 1ns/1ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_dly #(
  parameter DEPTH = `DCM_DLY_DEPTH
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // delay setting and signal
  input  wire [5:0] dly_code,
  input  wire       sig_in,
  output wire       sig_out
);
  reg  [DEPTH-1:0] sr_r;
  wire [4:0]       tap = dly_code[5:1];
  // 0 adds nothing, code 2k takes tap k, which is k+1 periods late
  assign sig_out = (dly_code == 6'h00) ? sig_in : sr_r[tap];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      sr_r <= {DEPTH{1'b0}};
    else
      sr_r <= {sr_r[DEPTH-2:0], sig_in};
  end
endmodule // dcm_dly
`default_nettype wire

// *** dcm_panel.sv ***
// display side model counting dot clock rising edges
`timescale 1ns/1ps
`default_nettype none
module dcm_panel (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // display pin and counter
  input  wire logic        dot_clock_out_pin,
  input  wire logic        cnt_clr,
  output var  logic [15:0] dot_edges
);
  logic dot_prev_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dot_prev_r <= 1'b0;
      dot_edges <= 16'h0000;
    end else begin
      dot_prev_r <= dot_clock_out_pin;
      if (cnt_clr)
        dot_edges <= 16'h0000;
      else if (dot_clock_out_pin && !dot_prev_r)
        dot_edges <= dot_edges + 16'h0001;
    end
  end
endmodule // dcm_panel
`default_nettype wire

// *** dcm_top.v ***
// display control mode registers, dot clock generation and output gating
`timescale 1ns/1ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_top #(
  parameter AW = 12,
  parameter DW = 24
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          soft_rst,
  // apb slave
  input  wire [AW-1:0] paddr,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output wire          pready,
  output wire          pslverr,
  output reg  [31:0]   prdata,
  // timing generator side
  input  wire          vsync_start,
  input  wire          hsync_raw,
  input  wire          vsync_raw,
  input  wire          csync_raw,
  input  wire          equalizing_raw,
  // pixel streams
  input  wire [DW-1:0] stream_a,
  input  wire [DW-1:0] stream_b,
  // pins
  input  wire          dot_clock_in_pin,
  output wire          dot_clock_out_pin,
  output reg           hsync_out,
  output reg           vsync_out,
  output reg           composite_sync_out,
  output reg  [DW-1:0] digital_rgb_out,
  output reg  [DW-1:0] analog_rgb_out,
  // decoded mode
  output reg           scan_interlace,
  output reg           scan_interlace_video,
  output reg           external_timing_enable,
  output reg  [5:0]    layer_enable,
  output wire          dot_tick
);
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  reg  [31:0] mode_r;
  reg  [31:0] mode_act_r;
  reg  [31:0] dot_r;
  reg  [31:0] dot_act_r;
  reg         rum_r;
  reg         ruf_r;
  reg  [31:0] mode_nxt;
  reg  [31:0] prim_view;
  reg  [31:0] wr_prim;
  reg  [31:0] rd_nxt;
  reg  [5:0]  m_eff;
  reg         alt_flip_r;
  reg         pin_s1_r;
  reg         pin_s2_r;
  reg         pin_s3_r;
  reg         pin_lvl_r;

  wire        setup    = psel & ~penable;
  wire        access   = psel & penable;
  wire        hit_prim = (paddr == `DCM_OFS_PRIMARY);
  wire        hit_alt  = (paddr == `DCM_OFS_ALTERNATE);
  wire        hit_upd  = (paddr == `DCM_OFS_UPDATE);
  wire        hit_dot  = (paddr == `DCM_OFS_DOTCLK);
  wire        mapped   = hit_prim | hit_alt | hit_upd | hit_dot;
  wire        wr       = access & pwrite & mapped;
  wire        display_output_enable      = mode_act_r[`DCM_DEN_BIT];
  wire        sf       = mode_act_r[`DCM_SF_BIT];
  wire [5:0]  m_act    = mode_act_r[`DCM_SC_HI:`DCM_SC_LO];
  wire        reference_clock_source      = mode_act_r[`DCM_CKS_BIT];

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // primary view of the single stored register
  always @* begin
    prim_view = mode_r;
    prim_view[`DCM_L5_BIT] = 1'b0;
    prim_view[`DCM_L4_BIT] = 1'b0;
    prim_view[`DCM_L2_BIT] = mode_r[`DCM_L2_BIT];
    prim_view[`DCM_L3_BIT] = mode_r[`DCM_L4_BIT];
    prim_view[`DCM_SC_HI:`DCM_SC_LO] = {1'b0, mode_r[`DCM_SC_HI:`DCM_SC_LO+1]};
  end

  // primary write translated to alternate format
  always @* begin
    wr_prim = merge(prim_view, pwdata, pstrb);
    mode_nxt = wr_prim & `DCM_ALT_MASK;
    mode_nxt[`DCM_L2_BIT] = wr_prim[`DCM_L2_BIT];
    mode_nxt[`DCM_L3_BIT] = wr_prim[`DCM_L2_BIT];
    mode_nxt[`DCM_L4_BIT] = wr_prim[`DCM_L3_BIT];
    mode_nxt[`DCM_L5_BIT] = wr_prim[`DCM_L3_BIT];
    // top bit of n is ignored; n=0 keeps the undivided code
    if (wr_prim[`DCM_SC_HI-1:`DCM_SC_LO] == 5'h00)
      mode_nxt[`DCM_SC_HI:`DCM_SC_LO] = `DCM_SC_ZERO;
    else
      mode_nxt[`DCM_SC_HI:`DCM_SC_LO] = {wr_prim[`DCM_SC_HI-1:`DCM_SC_LO], 1'b1};
  end

  // read mux
  always @* begin
    rd_nxt = 32'h00000000;
    if (hit_prim)
      rd_nxt = prim_view;
    else if (hit_alt)
      rd_nxt = mode_r;
    else if (hit_upd)
      rd_nxt = {30'h00000000, ruf_r, rum_r};
    else if (hit_dot)
      rd_nxt = dot_r;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= rd_nxt;
  end

  // mode register: no soft reset term on purpose
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      mode_r <= `DCM_MODE_RESET;
    else if (wr && hit_prim)
      mode_r <= mode_nxt;
    else if (wr && hit_alt)
      mode_r <= merge(mode_r, pwdata, pstrb) & `DCM_ALT_MASK;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      dot_r <= 32'h00000000;
    else if (soft_rst)
      dot_r <= 32'h00000000;
    else if (wr && hit_dot)
      dot_r <= merge(dot_r, pwdata, pstrb) & `DCM_DOT_MASK;
  end

  // update control; a new request in the vsync cycle survives the clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rum_r <= 1'b0;
      ruf_r <= 1'b0;
    end else if (soft_rst) begin
      rum_r <= 1'b0;
      ruf_r <= 1'b0;
    end else begin
      if (wr && hit_upd && pstrb[0])
        rum_r <= pwdata[`DCM_RUM_BIT];
      if (wr && hit_upd && pstrb[0] && pwdata[`DCM_RUF_BIT] && rum_r)
        ruf_r <= 1'b1;
      else if (vsync_start || !rum_r)
        ruf_r <= 1'b0;
    end
  end

  // active copies that steer the display logic
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_act_r <= `DCM_MODE_RESET;
      dot_act_r  <= 32'h00000000;
    end else if (!rum_r || (ruf_r && vsync_start)) begin
      mode_act_r <= mode_r;
      dot_act_r  <= dot_r;
    end
  end

  // dot clock pin synchroniser; stages two and three must agree
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r  <= 1'b0;
      pin_s2_r  <= 1'b0;
      pin_s3_r  <= 1'b0;
      pin_lvl_r <= 1'b0;
    end else begin
      pin_s1_r <= dot_clock_in_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r)
        pin_lvl_r <= pin_s3_r;
    end
  end

  // pll reference is the system clock itself: one tick every cycle
  wire pin_rise = pin_s2_r & pin_s3_r & ~pin_lvl_r;
  wire ref_tick = reference_clock_source ? pin_rise : 1'b1;

  // pll cannot run ratios 1/1 to 1/5; those fall back to undivided
  always @* begin
    m_eff = m_act;
    if (!reference_clock_source && m_act <= `DCM_SC_PLL_MAX)
      m_eff = `DCM_SC_ZERO;
  end

  wire dclk;
  wire dclk_rise;
  wire dclk_fall;
  wire dclk_dly;

  dcm_clkdiv u_div (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ref_tick  (ref_tick),
    .ratio_m   (m_eff),
    .dclk_r    (dclk),
    .dclk_rise (dclk_rise),
    .dclk_fall (dclk_fall)
  );

  dcm_dly #(
    .DEPTH (`DCM_DLY_DEPTH)
  ) u_dly (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .dly_code (dot_act_r[`DCM_DLY_HI:`DCM_DLY_LO]),
    .sig_in   (dclk),
    .sig_out  (dclk_dly)
  );

  // display with output enable off holds the pin low regardless of inversion
  assign dot_clock_out_pin = display_output_enable & (dclk_dly ^ dot_act_r[`DCM_INV_BIT]);
  assign dot_tick = dclk_rise;

  // sync, layer and mode outputs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hsync_out              <= 1'b1;
      vsync_out              <= 1'b1;
      composite_sync_out     <= 1'b1;
      scan_interlace         <= 1'b0;
      scan_interlace_video   <= 1'b0;
      external_timing_enable <= 1'b0;
      layer_enable           <= 6'h00;
    end else begin
      // inactive level is the inverse of the active one
      hsync_out          <= (display_output_enable & hsync_raw) ^ ~sf;
      vsync_out          <= (display_output_enable & vsync_raw) ^ ~sf;
      composite_sync_out <= (display_output_enable & (csync_raw | (equalizing_raw & mode_act_r[`DCM_EEQ_BIT]))) ^ ~sf;
      scan_interlace       <= mode_act_r[`DCM_SYNC_HI];
      scan_interlace_video <= mode_act_r[`DCM_SYNC_HI] & mode_act_r[`DCM_SYNC_LO];
      external_timing_enable <= mode_act_r[`DCM_ESY_BIT];
      layer_enable <= display_output_enable ? mode_act_r[`DCM_L5_BIT:`DCM_L0_BIT] : 6'h00;
    end
  end

  // pixel outputs
  wire edge_mode = dot_act_r[`DCM_EDGE_BIT];
  wire parallel  = dot_act_r[`DCM_POM_BIT];

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      digital_rgb_out <= {DW{1'b0}};
      analog_rgb_out  <= {DW{1'b0}};
      alt_flip_r      <= 1'b0;
    end else if (!display_output_enable) begin
      digital_rgb_out <= {DW{1'b0}};
      analog_rgb_out  <= {DW{1'b0}};
      alt_flip_r      <= 1'b0;
    end else if (parallel) begin
      alt_flip_r <= 1'b0;
      if (dclk_rise) begin
        digital_rgb_out <= stream_a;
        analog_rgb_out  <= stream_b;
      end
    end else if (edge_mode) begin
      // both edges: stream a on rise, stream b on fall
      alt_flip_r <= 1'b0;
      if (dclk_rise)
        digital_rgb_out <= stream_a;
      else if (dclk_fall)
        digital_rgb_out <= stream_b;
    end else if (dclk_rise) begin
      // single edge multiplex alternates streams on rising edges
      digital_rgb_out <= alt_flip_r ? stream_b : stream_a;
      alt_flip_r      <= ~alt_flip_r;
    end
  end

endmodule // dcm_top
`default_nettype wire

// *** dcm_top_assertions.sv ***
// port checker for the display control mode block
`timescale 1ns/1ps
`default_nettype none
module dcm_chk #(
  parameter AW = 12,
  parameter DW = 24
) (
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          soft_rst,
  // apb
  input wire logic [AW-1:0] paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [31:0]   prdata,
  // decoded
  input wire logic [5:0]    layer_enable
);
  logic       acc;
  logic       map;
  logic       rum_r;
  logic [5:0] exp_r;
  assign acc = psel && penable;
  assign map = paddr == 12'h000 || paddr == 12'h100 || paddr == 12'h104 || paddr == 12'h108;
  // deferred mode hides layer writes until vsync, so only immediate mode is judged
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rum_r <= 1'b0;
    else if (soft_rst)
      rum_r <= 1'b0;
    else if (acc && pwrite && paddr == 12'h104 && pstrb[0])
      rum_r <= pwdata[0];
  end
  always @(posedge clk_sys) begin
    if (acc && pwrite && paddr == 12'h000)
      exp_r <= {{2{pwdata[19]}}, {2{pwdata[18]}}, pwdata[17:16]};
    else if (acc && pwrite && paddr == 12'h100)
      exp_r <= pwdata[21:16];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && !map |-> pslverr) else $error("no error on unmapped access");
  a_mapped_ok: assert property (acc && map |-> !pslverr) else $error("error on mapped access");
  a_unmapped_zero: assert property (acc && !map && !pwrite |-> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_den_gate: assert property (acc && pwrite && (paddr == 12'h000 || paddr == 12'h100) && !rum_r && pstrb[3]
    && !pwdata[31] |-> ##[1:3] layer_enable == 6'h00) else $error("layers shown while disabled");
  a_layer_pair: assert property (acc && pwrite && paddr == 12'h000 && !rum_r && pstrb == 4'hF
    && pwdata[31] |-> ##[1:3] layer_enable == exp_r) else $error("paired layer enables wrong");
  a_layer_each: assert property (acc && pwrite && paddr == 12'h100 && !rum_r && pstrb == 4'hF
    && pwdata[31] |-> ##[1:3] layer_enable == exp_r) else $error("single layer enables wrong");
endmodule // dcm_chk
bind dcm_top dcm_chk #(.AW(AW), .DW(DW)) chk_u (.clk_sys, .rst_n, .soft_rst, .paddr, .psel, .penable,
  .pwrite, .pwdata, .pstrb, .pready, .pslverr, .prdata, .layer_enable);
`default_nettype wire

// *** dcm_top_test.sv ***
// self-checking bench for the display control mode block
`timescale 1ns/1ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_top_test;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        soft_rst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic        vs_start = 1'b0;
  logic        hs_raw = 1'b0;
  logic        eq_raw = 1'b0;
  logic        cnt_clr = 1'b0;
  logic [1:0]  ext_cnt = 2'b00;
  logic [23:0] v1;
  wire  logic  pready, pslverr, dot_pin, hs, vs, cs, si, siv, ete, tick;
  wire  logic [31:0] prdata;
  wire  logic [5:0]  lay;
  wire  logic [15:0] edges;
  wire  logic [23:0] rgb_d, rgb_a;
  logic [31:0] rd;
  logic        er;
  int          p3, p5, p7;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #50 clk_sys = ~clk_sys;
  // external dot clock source, four system clocks per period
  always @(posedge clk_sys) ext_cnt <= ext_cnt + 2'b01;
  dcm_top dut_u (.clk_sys, .rst_n, .soft_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF),
    .pready, .pslverr, .prdata, .vsync_start(vs_start), .hsync_raw(hs_raw), .vsync_raw(hs_raw),
    .csync_raw(hs_raw), .equalizing_raw(eq_raw), .stream_a(24'h5A5A5A), .stream_b(24'hA5A5A5),
    .dot_clock_in_pin(ext_cnt[1]), .dot_clock_out_pin(dot_pin), .hsync_out(hs), .vsync_out(vs),
    .composite_sync_out(cs), .digital_rgb_out(rgb_d), .analog_rgb_out(rgb_a), .scan_interlace(si),
    .scan_interlace_video(siv), .external_timing_enable(ete), .layer_enable(lay), .dot_tick(tick));
  dcm_panel pnl_u (.clk_sys, .rst_n, .dot_clock_out_pin(dot_pin), .cnt_clr, .dot_edges(edges));
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_mismatch++;
    complete_run();
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50)
      hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // period in system clocks between two dot clock rising edge ticks
  task automatic per(output int p);
    int i;
    i = 0;
    wt(40);
    while (tick !== 1'b1 && i < 300) begin
      wt(1);
      i++;
    end
    p = 0;
    do begin
      wt(1);
      p++;
    end while (tick !== 1'b1 && p < 300);
    if (i >= 300 || p >= 300)
      hang();
  endtask
  // system clocks from a dot clock tick until the pin reaches lvl
  task automatic lag(input logic lvl, output int d);
    int i;
    i = 0;
    wt(4);
    while (tick !== 1'b1 && i < 300) begin
      wt(1);
      i++;
    end
    d = 0;
    do begin
      wt(1);
      d++;
    end while (dot_pin !== lvl && d < 40);
    if (i >= 300)
      hang();
  endtask
  task automatic drv(input logic h);
    @(posedge clk_sys);
    hs_raw <= h;
    eq_raw <= 1'b1;
  endtask
  task automatic t_reset;
    apb(0, `DCM_OFS_ALTERNATE, 0);
    chk(rd, 32'h00001D00);
    apb(0, `DCM_OFS_PRIMARY, 0);
    chk(rd, 32'h00000E00);
    apb(0, `DCM_OFS_UPDATE, 0);
    chk(rd, 32'h00000000);
  endtask
  task automatic t_scale;
    apb(1, `DCM_OFS_PRIMARY, 32'h80070300);
    apb(0, `DCM_OFS_ALTERNATE, 0);
    chk(rd, 32'h800F0700);
    wt(4);
    chk(lay, 6'h0F);
    per(p3);
    apb(1, `DCM_OFS_ALTERNATE, 32'h80150700);
    wt(4);
    chk(lay, 6'h15);
    per(p7);
    chk(p3, 8);
    chk(p7, 8);
    apb(1, `DCM_OFS_ALTERNATE, 32'h80150500);
    per(p5);
    chk(p5, 6);
    apb(0, `DCM_OFS_PRIMARY, 0);
    chk(rd, 32'h800D0200);
  endtask
  task automatic t_sync;
    for (int k = 0; k < 8; k++) begin
      apb(1, `DCM_OFS_PRIMARY, {1'b1, 23'h000000, k[2], 3'b000, k[2], k[0], k[1:0]});
      drv(1'b1);
      wt(4);
      chk({hs, vs, cs}, {k[2], k[2], k[2]});
      chk({siv, si | siv, ete}, {k[1:0] == 2'b11, k[1], k[0]});
      drv(1'b0);
      wt(4);
      chk({hs, vs, cs}, {~k[2], ~k[2], 1'b1});
    end
    drv(1'b1);
    apb(1, `DCM_OFS_PRIMARY, 32'h00000000);
    wt(4);
    chk({lay, hs}, 7'h01);
    chk(rgb_d, 24'h000000);
    @(posedge clk_sys) cnt_clr <= 1'b1;
    @(posedge clk_sys) cnt_clr <= 1'b0;
    wt(60);
    chk(edges, 16'h0000);
  endtask
  task automatic t_defer;
    apb(1, `DCM_OFS_UPDATE, 32'h00000001);
    apb(1, `DCM_OFS_UPDATE, 32'h00000003);
    apb(0, `DCM_OFS_UPDATE, 0);
    chk(rd, 32'h00000003);
    apb(1, `DCM_OFS_PRIMARY, 32'h80030000);
    wt(6);
    chk(lay, 6'h00);
    @(posedge clk_sys) vs_start <= 1'b1;
    @(posedge clk_sys) vs_start <= 1'b0;
    wt(4);
    chk(lay, 6'h03);
    apb(0, `DCM_OFS_UPDATE, 0);
    chk(rd, 32'h00000001);
  endtask
  task automatic t_soft;
    apb(1, `DCM_OFS_DOTCLK, 32'h0000073E);
    apb(0, `DCM_OFS_DOTCLK, 0);
    chk(rd, 32'h0000073E);
    @(posedge clk_sys) soft_rst <= 1'b1;
    @(posedge clk_sys) soft_rst <= 1'b0;
    apb(0, `DCM_OFS_ALTERNATE, 0);
    chk(rd, 32'h80030000);
    apb(0, `DCM_OFS_DOTCLK, 0);
    chk(rd, 32'h00000000);
    apb(0, 12'h0FC, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1, 12'h10C, 32'hFFFFFFFF);
    apb(0, `DCM_OFS_ALTERNATE, 0);
    chk(rd, 32'h80030000);
  endtask
  // pll ratios up to five fall back to undivided; the pin source divides any ratio
  task automatic t_dot;
    apb(1, `DCM_OFS_ALTERNATE, 32'h80030300);
    per(p3);
    chk(p3, 2);
    apb(1, `DCM_OFS_ALTERNATE, 32'h80038100);
    per(p3);
    chk(p3, 8);
    apb(1, `DCM_OFS_ALTERNATE, 32'h80030700);
    wt(40);
    @(posedge clk_sys) cnt_clr <= 1'b1;
    @(posedge clk_sys) cnt_clr <= 1'b0;
    wt(80);
    chk(edges, 16'h000A);
    lag(1'b1, p3);
    chk(p3, 1);
    apb(1, `DCM_OFS_DOTCLK, 32'h00000102);
    lag(1'b0, p3);
    chk(p3, 3);
  endtask
  task automatic t_pix;
    apb(1, `DCM_OFS_DOTCLK, 32'h00000400);
    wt(20);
    chk(rgb_d, 24'h5A5A5A);
    chk(rgb_a, 24'hA5A5A5);
    apb(1, `DCM_OFS_DOTCLK, 32'h00000200);
    lag(1'b1, p3);
    chk(rgb_d, 24'h5A5A5A);
    wt(4);
    chk(rgb_d, 24'hA5A5A5);
    apb(1, `DCM_OFS_DOTCLK, 32'h00000000);
    lag(1'b1, p3);
    v1 = rgb_d;
    wt(8);
    chk(v1 ^ rgb_d, 24'hFFFFFF);
    chk(v1 == 24'h5A5A5A || v1 == 24'hA5A5A5, 1'b1);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_scale();
    t_sync();
    t_defer();
    t_soft();
    t_dot();
    t_pix();
    complete_run();
  end
endmodule // dcm_top_test
`default_nettype wire
